// file: pwm_timer_pkg.sv
// shared register map, field layout and reset values for the pwm timer
package pwm_timer_pkg;

  // ***************************************************
  // register indices, byte address is four times these
  // ***************************************************
  localparam logic [6:0] IDX_DUTY3 = 7'h73;
  localparam logic [6:0] IDX_DUTY2 = 7'h74;
  localparam logic [6:0] IDX_DUTY1 = 7'h75;
  localparam logic [6:0] IDX_DUTY0 = 7'h76;
  localparam logic [6:0] IDX_PWM_OUTPUT_CONTROL = 7'h77;
  localparam logic [6:0] IDX_CSR = 7'h78;
  localparam logic [6:0] IDX_CAR = 7'h79;
  localparam logic [6:0] IDX_ARR = 7'h7a;
  localparam logic [6:0] IDX_CAPCSR = 7'h7b;
  localparam logic [6:0] IDX_CAP1 = 7'h7c;
  localparam logic [6:0] IDX_CAP2 = 7'h7d;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int CSR_EXTERNAL_CLOCK_SELECT = 7;
  localparam int CSR_TAP_HI = 6;
  localparam int CSR_TAP_LO = 4;
  localparam int CSR_RUN = 3;
  localparam int CSR_FORCED_RELOAD = 2;
  localparam int CSR_OIE = 1;
  localparam int CSR_OVF = 0;
  localparam int PWM_OUTPUT_CONTROL_OE_LO = 4;
  localparam int CAP_CS_LO = 4;
  localparam int CAP_CIE_LO = 2;
  localparam int CAP_CF_LO = 0;

  // ***************************************************
  // reset values and fixed counts
  // ***************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hff;
  localparam logic [6:0] PRESC_RST = 7'h00;

endpackage

// file: capture_channel.sv
// one input capture channel: edge select, latch, sticky flag
`timescale 1ns/1ns
module capture_channel
  import pwm_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic edge_rising,
  input wire logic read_clear,
  input wire logic [7:0] count,
  output logic flag,
  output logic [7:0] value
);

  logic pin_prev_reg;
  logic hit;
  logic take;

  // selected transition on the pin, pins are already synchronous
  assign hit = edge_rising ? (pin & ~pin_prev_reg)
                           : (~pin & pin_prev_reg);
  // the read that frees the register also admits a new capture
  assign take = hit && (!flag || read_clear);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= pin;
  end

  // latch only while the flag is clear or being read clear, so an unread value survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      value <= RST_BYTE;
    else if (take)
      value <= count;
  end

  // a capture in the clearing cycle wins over the read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag <= 1'b0;
    else if (take)
      flag <= 1'b1;
    else if (read_clear)
      flag <= 1'b0;
  end

  cap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag && !read_clear |=> $stable(value))
    else $error("capture value changed while flag set");

endmodule

// file: pwm_auto_reload_timer.sv
// pwm auto-reload timer: prescaler, counter, pwm, capture, apb slave
// Behaviour
// - 8-bit counter steps on each prescaler tick
// - overflow reloads counter, prescaler untouched
// - counter access register reads/writes live count
// - tap select n divides input by 2^n
// - clock select 0 cpu, 1 external input
// - run enable clear freezes prescaler and counter
// - reset clears counter, prescaler, selects cpu clock
// - counter write or forced reload clears prescaler
// - hidden compares load from duty at overflow
// - output enable drives channel pin push-pull
// - pwm period is 256 minus reload counts
// - overflow drives pin to polarity start level
// - compare match returns pin to opposite level
// - pwm generation stops during halt
// - overflow sets sticky flag, irq if enabled
// - external mode counts 256 minus reload events
// - capture edge latches count, sets flag
// - capture blocked until value register read
// - capture irq pending while flag and enable
// - enabled capture edges wake from halt
// - status read clears overflow flag
// - forced reload is write-only, reads zero
// - capture read clears flag; edge 0 falling
// - polarity 0 high at or below compare
`timescale 1ns/1ns
module pwm_auto_reload_timer
  import pwm_timer_pkg::*;
#(
  parameter int N_PWM = 4,
  parameter int N_CAP = 2,
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_input_clock,
  input wire logic halt_mode,
  input wire logic [N_CAP-1:0] capture_input_pin,
  output logic [N_PWM-1:0] pwm_output_pin,
  output logic [N_PWM-1:0] pwm_output_enable,
  output logic overflow_irq,
  output logic capture_irq,
  output logic halt_wakeup
);

  // ***************************************************
  // state
  // ***************************************************
  logic external_clock_select;
  logic [2:0] prescale_tap_select;
  logic counter_run_enable;
  logic overflow_irq_enable;
  logic overflow_flag;
  logic [7:0] auto_reload_value;
  logic [7:0] count_reg;
  logic [6:0] presc_reg;
  logic [7:0] duty_cycle_buffer [N_PWM];
  logic [7:0] hidden_compare_value [N_PWM];
  logic [7:0] pwm_output_control;
  logic [N_CAP-1:0] capture_edge_select;
  logic [N_CAP-1:0] capture_irq_enable;
  logic [N_CAP-1:0] capture_flag;
  logic [7:0] capture_value_register [N_CAP];
  logic [N_CAP-1:0] cap_clear;
  logic [N_CAP-1:0] cf_seen_reg;
  logic ext_prev_reg;

  // ***************************************************
  // bus decode
  // ***************************************************
  logic [6:0] idx;
  logic addr_ok;
  logic hit;
  logic [7:0] rd_byte;
  logic setup;
  logic wr_go;
  logic rd_go;
  logic wr_car;
  logic wr_csr;
  logic forced_reload_go;

  assign idx = paddr[8:2];
  assign addr_ok = (paddr[ADDR_W-1:9] == '0) && (paddr[1:0] == 2'b00);
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pready && pwrite && hit;
  assign rd_go = psel && penable && pready && !pwrite && hit;
  assign wr_car = wr_go && (idx == IDX_CAR);
  assign wr_csr = wr_go && (idx == IDX_CSR);
  assign forced_reload_go = wr_csr && pwdata[CSR_FORCED_RELOAD];

  // read mux, unmapped addresses answer with an error
  always_comb
  begin
    rd_byte = RST_BYTE;
    hit = addr_ok;
    if (!addr_ok)
      hit = 1'b0;
    else if (idx == IDX_DUTY3)
      rd_byte = duty_cycle_buffer[3];
    else if (idx == IDX_DUTY2)
      rd_byte = duty_cycle_buffer[2];
    else if (idx == IDX_DUTY1)
      rd_byte = duty_cycle_buffer[1];
    else if (idx == IDX_DUTY0)
      rd_byte = duty_cycle_buffer[0];
    else if (idx == IDX_PWM_OUTPUT_CONTROL)
      rd_byte = pwm_output_control;
    else if (idx == IDX_CSR)
      rd_byte = {external_clock_select, prescale_tap_select,
                 counter_run_enable, 1'b0,
                 overflow_irq_enable, overflow_flag};
    else if (idx == IDX_CAR)
      rd_byte = count_reg;
    else if (idx == IDX_ARR)
      rd_byte = auto_reload_value;
    else if (idx == IDX_CAPCSR)
      rd_byte = {2'b00, capture_edge_select, capture_irq_enable,
                 capture_flag};
    else if (idx == IDX_CAP1)
      rd_byte = capture_value_register[0];
    else if (idx == IDX_CAP2)
      rd_byte = capture_value_register[1];
    else
      hit = 1'b0;
  end

  // no wait state: data sampled at setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      cf_seen_reg <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup)
      begin
        prdata <= {24'h000000, rd_byte};
        cf_seen_reg <= capture_flag;
      end
    end
  end

  // ***************************************************
  // software registers
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      external_clock_select <= 1'b0;
      prescale_tap_select <= 3'h0;
      counter_run_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end
    else if (wr_csr)
    begin
      external_clock_select <= pwdata[CSR_EXTERNAL_CLOCK_SELECT];
      prescale_tap_select <= pwdata[CSR_TAP_HI:CSR_TAP_LO];
      counter_run_enable <= pwdata[CSR_RUN];
      overflow_irq_enable <= pwdata[CSR_OIE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_reload_value <= RST_BYTE;
      pwm_output_control <= RST_BYTE;
      capture_edge_select <= '0;
      capture_irq_enable <= '0;
    end
    else if (wr_go && idx == IDX_ARR)
      auto_reload_value <= pwdata[7:0];
    else if (wr_go && idx == IDX_PWM_OUTPUT_CONTROL)
      pwm_output_control <= pwdata[7:0];
    else if (wr_go && idx == IDX_CAPCSR)
    begin
      capture_edge_select <= pwdata[CAP_CS_LO +: N_CAP];
      capture_irq_enable <= pwdata[CAP_CIE_LO +: N_CAP];
    end
  end

  // ***************************************************
  // prescaler and counter
  // ***************************************************
  logic ext_rise;
  logic in_tick;
  logic [6:0] tap_mask;
  logic cnt_tick;
  logic ovf_evt;

  // external input is synchronous; a rising edge is one event
  assign ext_rise = external_input_clock && !ext_prev_reg;
  // halt stops both sources, so no spurious steps while halted
  assign in_tick = counter_run_enable && !halt_mode &&
                   (external_clock_select ? ext_rise : 1'b1);
  assign tap_mask = 7'((8'h01 << prescale_tap_select) - 8'h01);
  assign cnt_tick = in_tick && ((presc_reg & tap_mask) == tap_mask);
  assign ovf_evt = cnt_tick && (count_reg == CNT_TOP) && !wr_car &&
                   !forced_reload_go;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_prev_reg <= 1'b0;
    else
      ext_prev_reg <= external_input_clock;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_reg <= PRESC_RST;
    else if (wr_car || forced_reload_go)
      presc_reg <= PRESC_RST;
    else if (in_tick)
      presc_reg <= presc_reg + 7'h01;
  end

  // overflow reloads rather than wrapping, giving 256-reload ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= RST_BYTE;
    else if (wr_car)
      count_reg <= pwdata[7:0];
    else if (forced_reload_go)
      count_reg <= auto_reload_value;
    else if (ovf_evt)
      count_reg <= auto_reload_value;
    else if (cnt_tick)
      count_reg <= count_reg + 8'h01;
  end

  // only clear the flag if the read actually showed it set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_flag <= 1'b0;
    else if (ovf_evt)
      overflow_flag <= 1'b1;
    else if (rd_go && idx == IDX_CSR && prdata[CSR_OVF])
      overflow_flag <= 1'b0;
  end

  // ***************************************************
  // pwm channels
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < N_PWM; g = g + 1)
    begin : gen_pwm
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          duty_cycle_buffer[g] <= RST_BYTE;
        else if (wr_go && idx == IDX_DUTY0 - 7'(g))
          duty_cycle_buffer[g] <= pwdata[7:0];
      end

      // double buffer: compare only moves at the period boundary
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          hidden_compare_value[g] <= RST_BYTE;
        else if (ovf_evt)
          hidden_compare_value[g] <= duty_cycle_buffer[g];
      end

      // level follows count vs compare, polarity applies at once
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pwm_output_pin[g] <= 1'b0;
        else if (!halt_mode)
          pwm_output_pin[g] <=
            (count_reg <= hidden_compare_value[g]) ^
            pwm_output_control[g];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pwm_output_enable[g] <= 1'b0;
        else
          pwm_output_enable[g] <= pwm_output_control[PWM_OUTPUT_CONTROL_OE_LO + g];
      end
    end
  endgenerate

  // ***************************************************
  // capture channels
  // ***************************************************
  generate
    for (g = 0; g < N_CAP; g = g + 1)
    begin : gen_cap
      assign cap_clear[g] = rd_go && (idx == IDX_CAP1 + 7'(g)) &&
                            cf_seen_reg[g];
      capture_channel u_cap (
        .pclk(pclk),
        .presetn(presetn),
        .pin(capture_input_pin[g]),
        .edge_rising(capture_edge_select[g]),
        .read_clear(cap_clear[g]),
        .count(count_reg),
        .flag(capture_flag[g]),
        .value(capture_value_register[g])
      );
    end
  endgenerate

  // ***************************************************
  // interrupt requests and wake-up
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
      halt_wakeup <= 1'b0;
    end
    else
    begin
      overflow_irq <= overflow_flag && overflow_irq_enable;
      capture_irq <= |(capture_flag & capture_irq_enable);
      halt_wakeup <= halt_mode &&
                     |(capture_flag & capture_irq_enable);
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  cnt_step_a: assert property (
    cnt_tick && !ovf_evt && !wr_car && !forced_reload_go
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("counter did not step on tick");

  reload_a: assert property (
    ovf_evt |=> count_reg == $past(auto_reload_value) &&
    presc_reg == $past(presc_reg) + 7'h01)
    else $error("overflow reload wrong");

  freeze_a: assert property (
    !counter_run_enable && !wr_car && !forced_reload_go
    |=> $stable(count_reg) && $stable(presc_reg))
    else $error("counter moved while stopped");

  presc_clr_a: assert property (
    wr_car || forced_reload_go |=> presc_reg == PRESC_RST)
    else $error("prescaler not cleared on init");

  cmp_load_a: assert property (
    ovf_evt |=> hidden_compare_value[0] == $past(duty_cycle_buffer[0]))
    else $error("compare not loaded at overflow");

  pwm_start_a: assert property (
    ovf_evt && !halt_mode ##1 !halt_mode &&
    hidden_compare_value[0] >= count_reg
    |=> pwm_output_pin[0] == !$past(pwm_output_control[0]))
    else $error("pwm start level wrong");

  ovf_irq_a: assert property (
    ovf_evt ##1 overflow_irq_enable |=> overflow_irq)
    else $error("overflow irq missing");

  cap_irq_a: assert property (
    (capture_flag & capture_irq_enable) != '0 |=> capture_irq)
    else $error("capture irq not pending");

  bus_ready_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");

endmodule

// file: ext_pin_model.sv
// model of the pins outside the timer: event input and capture inputs
`timescale 1ns/1ns
module ext_pin_model
(
  input wire logic pclk,
  output logic ext_clk,
  output logic [1:0] cap_pin
);
  // ***************************************************
  // pin drivers
  // ***************************************************
  // all three pins idle low until a scenario asks for activity
  initial
  begin
    ext_clk = 1'b0;
    cap_pin = 2'b00;
  end

  // two cycles high and three low between events, so the synchronous edge detector
  // never sees two events merge into one
  task automatic events(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // a capture pin moves once, then holds long enough to be seen
  task automatic level(input int ch, input logic v);
    @(posedge pclk);
    cap_pin[ch] <= v;
    repeat (3) @(posedge pclk);
  endtask
endmodule

// file: pwm_auto_reload_timer_test.sv
// self-checking bench for the pwm auto-reload timer
`timescale 1ns/1ns
module pwm_auto_reload_timer_test
  import pwm_timer_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, halt_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic pready, pslverr, ext_clk, overflow_irq, capture_irq, halt_wakeup;
  logic [1:0] cap_pin;
  logic [3:0] pwm_pin, pwm_oe;
  logic [8:0] notes[$];
  logic [7:0] r;
  logic [3:0] held;
  logic [6:0] idx_list[7] = '{IDX_CSR, IDX_CAR, IDX_ARR, IDX_PWM_OUTPUT_CONTROL,
    IDX_CAPCSR, IDX_CAP1, IDX_DUTY0};
  int errors, n_tests, cycles;

  // ***************************************************
  // design and pin model
  // ***************************************************
  pwm_auto_reload_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_input_clock(ext_clk), .halt_mode(halt_mode),
    .capture_input_pin(cap_pin), .pwm_output_pin(pwm_pin),
    .pwm_output_enable(pwm_oe), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq), .halt_wakeup(halt_wakeup));

  ext_pin_model pins (.pclk(pclk), .ext_clk(ext_clk), .cap_pin(cap_pin));

  // ***************************************************
  // helpers
  // ***************************************************
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input string nm, input logic [8:0] seen,
    input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // pready is taken at the rising edge that ends the access phase
  task automatic apb(input logic w, input logic [6:0] idx,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'b000, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  // the expectation is noted first; the watcher below compares it
  task automatic rd(input logic [6:0] idx, input logic [8:0] exp);
    notes.push_back(exp);
    apb(1'b0, idx, 8'h00);
  endtask

  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // read answers are taken at the completing edge, error bit on top
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", {pslverr, prdata[7:0]}, notes.pop_front());

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  // ***************************************************
  // scenarios
  // ***************************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    halt_mode = 1'b0;
    seed = 32'h492c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped index that must be refused
    foreach (idx_list[i]) rd(idx_list[i], 9'h000);
    rd(7'h10, 9'h100);
    // live counter access, frozen while the run bit is clear
    seed = xs(seed);
    r = seed[7:0];
    wr(IDX_CAR, r);
    rd(IDX_CAR, {1'b0, r});
    repeat (20) @(posedge pclk);
    rd(IDX_CAR, {1'b0, r});
    // cpu clock, tap 0: the run bit stands for three edges between writes
    wr(IDX_CSR, 8'h08);
    wr(IDX_CSR, 8'h00);
    rd(IDX_CAR, {1'b0, r + 8'h03});
    // taps 0 to 2 each divide the event clock so three ticks land
    for (int n = 0; n < 3; n++)
    begin
      wr(IDX_CAR, 8'h10);
      wr(IDX_CSR, 8'h88 | 8'(n << 4));
      pins.events(3 << n);
      wr(IDX_CSR, 8'h80);
      rd(IDX_CAR, 9'h013);
    end
    // overflow after 256 minus reload events, pwm double buffering
    wr(IDX_PWM_OUTPUT_CONTROL, 8'hf0);
    wr(IDX_DUTY0, 8'hfe);
    wr(IDX_DUTY1, 8'hff);
    wr(IDX_ARR, 8'hfd);
    wr(IDX_CSR, 8'h8e);
    pins.events(2);
    rd(IDX_CSR, 9'h08a);
    settle;
    chk("pwm", {5'h00, pwm_pin}, 9'h000);
    pins.events(1);
    settle;
    chk("ovf irq", {8'h00, overflow_irq}, 9'h001);
    chk("pwm", {5'h00, pwm_pin}, 9'h003);
    chk("pwm oe", {5'h00, pwm_oe}, 9'h00f);
    rd(IDX_CSR, 9'h08b);
    rd(IDX_CSR, 9'h08a);
    rd(IDX_CAR, 9'h0fd);
    wr(IDX_PWM_OUTPUT_CONTROL, 8'hf1);
    settle;
    chk("pwm", {5'h00, pwm_pin}, 9'h002);
    pins.events(2);
    settle;
    chk("pwm", {5'h00, pwm_pin}, 9'h003);
    // capture latches once, then stays blocked until read
    wr(IDX_CSR, 8'h00);
    seed = xs(seed);
    r = seed[7:0];
    wr(IDX_CAR, r);
    wr(IDX_CAPCSR, 8'h14);
    pins.level(0, 1'b1);
    settle;
    chk("cap irq", {8'h00, capture_irq}, 9'h001);
    rd(IDX_CAPCSR, 9'h015);
    pins.level(0, 1'b0);
    wr(IDX_CAR, ~r);
    pins.level(0, 1'b1);
    rd(IDX_CAP1, {1'b0, r});
    rd(IDX_CAPCSR, 9'h014);
    // falling edge on the second channel wakes a halted device
    wr(IDX_CAPCSR, 8'h08);
    pins.level(1, 1'b1);
    rd(IDX_CAPCSR, 9'h008);
    halt_mode <= 1'b1;
    pins.level(1, 1'b0);
    settle;
    chk("wakeup", {8'h00, halt_wakeup}, 9'h001);
    rd(IDX_CAP2, {1'b0, ~r});
    // a polarity flip while halted must not reach the pins
    held = pwm_pin;
    wr(IDX_PWM_OUTPUT_CONTROL, 8'hff);
    settle;
    chk("halt pwm", {5'h00, pwm_pin}, {5'h00, held});
    wrap_up();
  end
endmodule
